// >>> iocss_blink.sv
// Indicator flash divider with 2 Hz, 1 Hz and 0.5 Hz square waves
`include "iocss_consts.svh"
module iocss_blink import iocss_pkg::*; #(
   parameter int unsigned QTR_CYC = `IOCSS_QTR_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Flash phases
   output logic blink_2hz,
   output logic blink_1hz,
   output logic blink_05hz
);
   logic [`IOCSS_DIV_W-1:0] div_r;
   logic [2:0] phase_r;
   logic qtr_tick;

   // Quarter-second enable pulse
   assign qtr_tick = (div_r == `IOCSS_DIV_W'(QTR_CYC - 1)); // RULE17

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_r <= '0;
         phase_r <= 3'h0;
      end else begin
         div_r <= qtr_tick ? '0 : div_r + 1'b1;
         phase_r <= qtr_tick ? phase_r + 3'h1 : phase_r;
      end
   end

   // Equal on and off halves
   assign blink_2hz = phase_r[0]; // RULE17
   assign blink_1hz = phase_r[1];
   assign blink_05hz = phase_r[2];
endmodule

// >>> iocss_consts.svh
// Constants of the IO controller start-up supervisor
`ifndef IOCSS_CONSTS_SVH
`define IOCSS_CONSTS_SVH
`define IOCSS_CLK_HZ 50000000
`define IOCSS_QTR_MS 250
`define IOCSS_QTR_CYC (`IOCSS_CLK_HZ / 1000 * `IOCSS_QTR_MS)
`define IOCSS_DIV_W 24
`define IOCSS_DEV_MAX 4'h8
`define IOCSS_IDX_W 4
`define IOCSS_ADDR_W 3
`define IOCSS_DATA_W 32
`define IOCSS_MEM_DEPTH 8
`endif

// >>> iocss_mem.sv
// Device address table with registered read data
`include "iocss_consts.svh"
module iocss_mem import iocss_pkg::*; (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Write side
   input wire logic we,
   input wire iocss_addr_t waddr,
   input wire iocss_word_t wdata,
   // Read side
   input wire iocss_addr_t raddr,
   output iocss_word_t rdata
);
   iocss_word_t mem [`IOCSS_MEM_DEPTH];

   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= '0;
      end else begin
         rdata <= mem[raddr];
      end
   end
endmodule

// >>> iocss_pkg.sv
// Types of the IO controller start-up supervisor
`include "iocss_consts.svh"
package iocss_pkg;
   typedef enum logic [2:0] {
      ST_UNCFG = 3'h0,
      ST_PARAM = 3'h1,
      ST_LOAD = 3'h3,
      ST_DISCOVERY = 3'h2,
      ST_RELATION = 3'h6,
      ST_RUN = 3'h7
   } iocss_state_e;
   typedef logic [`IOCSS_DATA_W-1:0] iocss_word_t;
   typedef logic [`IOCSS_IDX_W-1:0] iocss_idx_t;
   typedef logic [`IOCSS_ADDR_W-1:0] iocss_addr_t;
endpackage

// >>> iocss_remote.sv
// Remote IO device model answering discovery and relation requests
module iocss_remote import iocss_pkg::*; (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Answer speed
   input wire logic slow,
   // Requests from the controller
   input wire logic disc_set,
   input wire logic rel_req,
   input wire iocss_addr_t dev_idx,
   input wire iocss_word_t dev_ip,
   // Answers
   output logic disc_ack,
   output logic rel_ack
);
   timeunit 1ns;
   timeprecision 1ps;
   iocss_word_t ip_seen [8];
   int n_rel = 0;
   initial begin
      disc_ack = 1'b0;
      rel_ack = 1'b0;
   end
   // Takes the assigned address, answers after a delay
   always @(posedge clk) begin
      if (rst_n && disc_set) begin
         ip_seen[dev_idx] = dev_ip;
         repeat (slow ? 6 : 1) @(posedge clk);
         #2 disc_ack = 1'b1;
         @(posedge clk);
         #2 disc_ack = 1'b0;
      end
   end
   // Counts relation set-ups, answers after a delay
   always @(posedge clk) begin
      if (rst_n && rel_req) begin
         n_rel++;
         repeat (slow ? 5 : 1) @(posedge clk);
         #2 rel_ack = 1'b1;
         @(posedge clk);
         #2 rel_ack = 1'b0;
      end
   end
endmodule

// >>> iocss_top.sv
// Start-up supervisor, indicators and cyclic data gating of the IO controller
// Functional notes
// (RULE1) Unconfigured after power-on: both network indicators stay dark.
// (RULE2) Unconfigured: no IO traffic originated, device-search requests still answered.
// (RULE3) Complete project reception triggers a fresh system start-up.
// (RULE4) Bus parameters without project: controller reachable at its IP address.
// (RULE5) Start-up assigns each configured device its IP via discovery protocol.
// (RULE6) Start-up sets up communication and application relation per device.
// (RULE7) New configuration is taken over automatically, without further request.
// (RULE8) Bus-fault indicator steady when a linked device has no bus cable.
// (RULE9) Bus-state indicator steady with valid configuration holding a device.
// (RULE10) Unsuitable interface parameters flash bus-state indicator at 1 Hz.
// (RULE11) Unusable own IP address flashes bus-state indicator at 0.5 Hz.
// (RULE12) Device not exchanging cyclic data after start-up blinks bus-fault indicator.
// (RULE13) All devices exchanging: bus-fault indicator off, system ready.
// (RULE14) STOP: telegrams still sent cyclically, marked invalid, data zero.
// (RULE15) STOP and RUN: input data copied cyclically into CPU input area.
// (RULE16) RUN: output data fetched from CPU and sent cyclically.
// (RULE17) Flash from clock divider, equal halves; steady fault beats flashing.
`include "iocss_consts.svh"
module iocss_top import iocss_pkg::*; #(
   parameter int unsigned QTR_CYC = `IOCSS_QTR_CYC
) (
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic RESETN,
   // Interface status
   input wire logic BUS_PARAM_OK,
   input wire logic IF_PARAM_OK,
   input wire logic OWN_IP_OK,
   input wire logic LINK_UP,
   // Configuration loader
   input wire logic CFG_BEGIN,
   input wire logic CFG_WR,
   input wire logic [`IOCSS_ADDR_W-1:0] CFG_IDX,
   input wire logic [`IOCSS_DATA_W-1:0] CFG_IP,
   input wire logic CFG_LINKED,
   input wire logic CFG_END,
   input wire logic [`IOCSS_IDX_W-1:0] CFG_COUNT,
   // CPU process image
   input wire logic CPU_RUN,
   input wire logic [`IOCSS_DATA_W-1:0] CPU_OUT_DATA,
   output logic CPU_OUT_RD,
   output logic CPU_IN_STB,
   output logic [`IOCSS_DATA_W-1:0] CPU_IN_DATA,
   // Network control
   input wire logic NET_SEARCH_REQ,
   output logic NET_SEARCH_RSP,
   output logic NET_IO_EN,
   output logic HOST_REACH,
   output logic NET_DISCOVERY_SET,
   input wire logic NET_DISCOVERY_ACK,
   output logic NET_REL_REQ,
   input wire logic NET_REL_ACK,
   output logic [`IOCSS_ADDR_W-1:0] NET_DEV_IDX,
   output logic [`IOCSS_DATA_W-1:0] NET_DEV_IP,
   input wire logic [`IOCSS_DEV_MAX-1:0] DEV_EXCH,
   // Cyclic data
   input wire logic CYCLE_TICK,
   output logic TX_STB,
   output logic TX_DATA_VALID,
   output logic [`IOCSS_DATA_W-1:0] TX_DATA,
   input wire logic RX_STB,
   input wire logic [`IOCSS_DATA_W-1:0] RX_DATA,
   // Indicators
   output logic BUS_FAULT_INDICATOR,
   output logic BUS_STATE_INDICATOR,
   output logic COMM_READY
);
   function automatic logic [`IOCSS_DEV_MAX-1:0] dev_mask(input iocss_idx_t n);
      logic [`IOCSS_DEV_MAX-1:0] m;
      m = '0;
      for (int i = 0; i < `IOCSS_DEV_MAX; i++) begin
         m[i] = (`IOCSS_IDX_W'(i) < n);
      end
      return m;
   endfunction

   iocss_state_e state_r, state_nxt;
   iocss_idx_t idx_r, idx_nxt, cnt_r, cnt_nxt;
   logic pend_r, pend_nxt, rd_wait_r, rd_wait_nxt;
   logic disc_set_nxt, rel_req_nxt;
   logic [`IOCSS_DEV_MAX-1:0] linked_r;
   iocss_word_t mem_rdata;
   logic b2hz, b1hz, b05hz;

   // Decoding
   logic seq_done, cfgd, io_active, mem_we, bf_steady, bf_blink, all_exch;
   logic bf_nxt, stat_nxt, run_tick;
   iocss_idx_t idx_inc, cnt_clamp;
   assign seq_done = (idx_r >= cnt_r);
   assign idx_inc = idx_r + 1'b1;
   assign cnt_clamp = (CFG_COUNT > `IOCSS_DEV_MAX) ? `IOCSS_DEV_MAX : CFG_COUNT;
   assign cfgd = (state_r == ST_DISCOVERY) || (state_r == ST_RELATION) || (state_r == ST_RUN);
   assign io_active = cfgd; // RULE2
   assign mem_we = CFG_WR && (state_r == ST_LOAD);
   assign run_tick = CYCLE_TICK && (state_r == ST_RUN);
   assign bf_steady = cfgd && |(linked_r & dev_mask(cnt_r)) && !LINK_UP; // RULE8
   assign bf_blink = (state_r == ST_RUN) && |(dev_mask(cnt_r) & ~DEV_EXCH); // RULE12
   assign all_exch = (state_r == ST_RUN) && !bf_blink; // RULE13
   assign bf_nxt = bf_steady ? 1'b1 : (bf_blink && b2hz); // RULE17
   assign stat_nxt = !cfgd ? 1'b0 : // RULE1
                   !OWN_IP_OK ? b05hz : // RULE11
                   !IF_PARAM_OK ? b1hz : // RULE10
                   (cnt_r != '0); // RULE9

   // Start-up sequencing
   always_comb begin
      state_nxt = state_r;
      idx_nxt = idx_r;
      cnt_nxt = cnt_r;
      pend_nxt = pend_r;
      rd_wait_nxt = 1'b0;
      disc_set_nxt = 1'b0;
      rel_req_nxt = 1'b0;
      unique case (state_r)
         ST_UNCFG: begin
            if (BUS_PARAM_OK) begin
               state_nxt = ST_PARAM;
            end
         end
         ST_PARAM: begin
            if (!BUS_PARAM_OK) begin
               state_nxt = ST_UNCFG;
            end
         end
         ST_LOAD: begin
            if (CFG_END) begin
               state_nxt = ST_DISCOVERY; // RULE3 RULE7
               idx_nxt = '0;
               pend_nxt = 1'b0;
               cnt_nxt = cnt_clamp;
            end
         end
         ST_DISCOVERY: begin
            if (seq_done) begin
               state_nxt = ST_RELATION;
               idx_nxt = '0;
            end else if (pend_r) begin
               if (NET_DISCOVERY_ACK) begin
                  pend_nxt = 1'b0;
                  idx_nxt = idx_inc; // RULE5
               end
            end else if (rd_wait_r) begin
               disc_set_nxt = 1'b1; // RULE5
               pend_nxt = 1'b1;
            end else begin
               rd_wait_nxt = 1'b1;
            end
         end
         ST_RELATION: begin
            if (seq_done) begin
               state_nxt = ST_RUN;
            end else if (pend_r) begin
               if (NET_REL_ACK) begin
                  pend_nxt = 1'b0;
                  idx_nxt = idx_inc; // RULE6
               end
            end else begin
               rel_req_nxt = 1'b1; // RULE6
               pend_nxt = 1'b1;
            end
         end
         ST_RUN: begin
            state_nxt = ST_RUN;
         end
         default: begin
            state_nxt = ST_UNCFG;
         end
      endcase
      if (CFG_BEGIN) begin
         state_nxt = ST_LOAD; // RULE7
         pend_nxt = 1'b0;
      end
   end

   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         state_r <= ST_UNCFG;
         idx_r <= '0;
         cnt_r <= '0;
         pend_r <= 1'b0;
         rd_wait_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         idx_r <= idx_nxt;
         cnt_r <= cnt_nxt;
         pend_r <= pend_nxt;
         rd_wait_r <= rd_wait_nxt;
      end
   end

   // Linked flags of the loaded devices
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         linked_r <= '0;
      end else if (CFG_BEGIN) begin
         linked_r <= '0;
      end else if (mem_we) begin
         linked_r[CFG_IDX] <= CFG_LINKED;
      end
   end

   // Network requests and reachability
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         NET_SEARCH_RSP <= 1'b0;
         NET_IO_EN <= 1'b0;
         HOST_REACH <= 1'b0;
         NET_DISCOVERY_SET <= 1'b0;
         NET_REL_REQ <= 1'b0;
         NET_DEV_IDX <= '0;
         NET_DEV_IP <= '0;
      end else begin
         NET_SEARCH_RSP <= NET_SEARCH_REQ; // RULE2
         NET_IO_EN <= io_active; // RULE2
         HOST_REACH <= (state_r != ST_UNCFG); // RULE4
         NET_DISCOVERY_SET <= disc_set_nxt;
         NET_REL_REQ <= rel_req_nxt;
         NET_DEV_IDX <= (disc_set_nxt || rel_req_nxt) ? idx_r[`IOCSS_ADDR_W-1:0] : NET_DEV_IDX;
         NET_DEV_IP <= disc_set_nxt ? mem_rdata : NET_DEV_IP; // RULE5
      end
   end

   // Cyclic process data
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         CPU_OUT_RD <= 1'b0;
         TX_STB <= 1'b0;
         TX_DATA_VALID <= 1'b0;
         TX_DATA <= '0;
         CPU_IN_STB <= 1'b0;
         CPU_IN_DATA <= '0;
      end else begin
         CPU_OUT_RD <= run_tick && CPU_RUN; // RULE16
         TX_STB <= run_tick; // RULE14
         TX_DATA_VALID <= run_tick && CPU_RUN; // RULE14
         TX_DATA <= (run_tick && CPU_RUN) ? CPU_OUT_DATA : '0; // RULE14 RULE16
         CPU_IN_STB <= RX_STB && io_active; // RULE15
         CPU_IN_DATA <= (RX_STB && io_active) ? RX_DATA : CPU_IN_DATA; // RULE15
      end
   end

   // Indicators
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         BUS_FAULT_INDICATOR <= 1'b0;
         BUS_STATE_INDICATOR <= 1'b0;
         COMM_READY <= 1'b0;
      end else begin
         BUS_FAULT_INDICATOR <= bf_nxt;
         BUS_STATE_INDICATOR <= stat_nxt;
         COMM_READY <= all_exch; // RULE13
      end
   end

   iocss_mem u_mem (
      .clk(CORE_CLK),
      .rst_n(RESETN),
      .we(mem_we),
      .waddr(CFG_IDX),
      .wdata(CFG_IP),
      .raddr(idx_r[`IOCSS_ADDR_W-1:0]),
      .rdata(mem_rdata)
   );

   iocss_blink #(.QTR_CYC(QTR_CYC)) u_blink (
      .clk(CORE_CLK),
      .rst_n(RESETN),
      .blink_2hz(b2hz),
      .blink_1hz(b1hz),
      .blink_05hz(b05hz)
   );

   // Checks
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RESETN);

   property p_dark;
      (state_r == ST_UNCFG) |=> (!BUS_FAULT_INDICATOR && !BUS_STATE_INDICATOR);
   endproperty
   a_dark: assert property (p_dark) else $error("indicator lit while unconfigured"); // RULE1

   property p_quiet;
      (state_r inside {ST_UNCFG, ST_PARAM}) |=> (!NET_IO_EN && !NET_DISCOVERY_SET && !TX_STB);
   endproperty
   a_quiet: assert property (p_quiet) else $error("traffic while unconfigured"); // RULE2

   property p_search;
      NET_SEARCH_REQ |=> NET_SEARCH_RSP;
   endproperty
   a_search: assert property (p_search) else $error("search not answered"); // RULE2

   property p_restart;
      (state_r == ST_LOAD && CFG_END && !CFG_BEGIN) |=> (state_r == ST_DISCOVERY && idx_r == '0);
   endproperty
   a_restart: assert property (p_restart) else $error("no start-up after load"); // RULE3

   property p_reach;
      (state_r == ST_PARAM) [*2] |-> HOST_REACH;
   endproperty
   a_reach: assert property (p_reach) else $error("not reachable with bus parameters"); // RULE4

   property p_disc;
      (state_r == ST_DISCOVERY && !seq_done && !pend_r && !CFG_BEGIN) |-> ##[1:2] NET_DISCOVERY_SET;
   endproperty
   a_disc: assert property (p_disc) else $error("discovery request missing"); // RULE5

   property p_rel_done;
      (state_r == ST_RELATION && seq_done && !CFG_BEGIN) |=> (state_r == ST_RUN);
   endproperty
   a_rel_done: assert property (p_rel_done) else $error("relations done but not running"); // RULE6

   property p_bf_steady;
      bf_steady |=> BUS_FAULT_INDICATOR;
   endproperty
   a_bf_steady: assert property (p_bf_steady) else $error("bus fault not steady"); // RULE8

   property p_bs_on;
      (cfgd && OWN_IP_OK && IF_PARAM_OK && cnt_r != '0) |=> BUS_STATE_INDICATOR;
   endproperty
   a_bs_on: assert property (p_bs_on) else $error("bus state not lit"); // RULE9

   property p_bs_1hz;
      (cfgd && OWN_IP_OK && !IF_PARAM_OK) |=> (BUS_STATE_INDICATOR == $past(b1hz));
   endproperty
   a_bs_1hz: assert property (p_bs_1hz) else $error("bus state not at 1 Hz"); // RULE10

   property p_bs_05hz;
      (cfgd && !OWN_IP_OK) |=> (BUS_STATE_INDICATOR == $past(b05hz));
   endproperty
   a_bs_05hz: assert property (p_bs_05hz) else $error("bus state not at 0.5 Hz"); // RULE11

   property p_bf_blink;
      (!bf_steady && bf_blink) |=> (BUS_FAULT_INDICATOR == $past(b2hz));
   endproperty
   a_bf_blink: assert property (p_bf_blink) else $error("bus fault not blinking"); // RULE12

   property p_ready;
      (state_r == ST_RUN && !bf_blink && !bf_steady) |=> (!BUS_FAULT_INDICATOR && COMM_READY);
   endproperty
   a_ready: assert property (p_ready) else $error("not ready with all exchanging"); // RULE13

   property p_stop;
      (run_tick && !CPU_RUN) |=> (TX_STB && !TX_DATA_VALID && TX_DATA == '0 && !CPU_OUT_RD);
   endproperty
   a_stop: assert property (p_stop) else $error("bad telegram in STOP"); // RULE14

   property p_rx;
      (RX_STB && io_active) |=> (CPU_IN_STB && CPU_IN_DATA == $past(RX_DATA));
   endproperty
   a_rx: assert property (p_rx) else $error("input data not copied"); // RULE15

   property p_run;
      (run_tick && CPU_RUN) |=> (CPU_OUT_RD && TX_STB && TX_DATA_VALID && TX_DATA == $past(CPU_OUT_DATA));
   endproperty
   a_run: assert property (p_run) else $error("output data not sent in RUN"); // RULE16

   c_run: cover property (state_r == ST_RELATION ##1 state_r == ST_RUN);
   c_disc: cover property (NET_DISCOVERY_SET ##[1:20] NET_DISCOVERY_ACK);
   c_stop_tx: cover property (TX_STB && !TX_DATA_VALID);
   c_ready: cover property (COMM_READY);
endmodule

// >>> tb.sv
// Self-checking bench of the IO controller start-up supervisor
module tb import iocss_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rstn = 0, bus_ok = 0, if_ok = 1, ip_ok = 1, link = 1, slow = 0;
   logic cfg_b = 0, cfg_wr = 0, cfg_lk = 0, cfg_e = 0, run = 0, srch = 0, tick = 0, rx_stb = 0;
   iocss_addr_t cfg_idx = 0;
   iocss_word_t cfg_ip = 0, out_d = 0, rx_d = 0;
   logic [3:0] cfg_cnt = 0;
   logic [7:0] exch = 0;
   wire logic out_rd, in_stb, srsp, io_en, reach, dset, dack, rreq, rack, tx_stb, tx_v, bf, sti, rdy;
   wire iocss_addr_t didx;
   wire iocss_word_t in_d, dip, tx_d;
   int error_cnt = 0, n_tests = 0;

   iocss_top #(.QTR_CYC(4)) DUT (.CORE_CLK(clk), .RESETN(rstn), .BUS_PARAM_OK(bus_ok),
      .IF_PARAM_OK(if_ok), .OWN_IP_OK(ip_ok), .LINK_UP(link), .CFG_BEGIN(cfg_b), .CFG_WR(cfg_wr),
      .CFG_IDX(cfg_idx), .CFG_IP(cfg_ip), .CFG_LINKED(cfg_lk), .CFG_END(cfg_e), .CFG_COUNT(cfg_cnt),
      .CPU_RUN(run), .CPU_OUT_DATA(out_d), .CPU_OUT_RD(out_rd), .CPU_IN_STB(in_stb),
      .CPU_IN_DATA(in_d), .NET_SEARCH_REQ(srch), .NET_SEARCH_RSP(srsp), .NET_IO_EN(io_en),
      .HOST_REACH(reach), .NET_DISCOVERY_SET(dset), .NET_DISCOVERY_ACK(dack), .NET_REL_REQ(rreq),
      .NET_REL_ACK(rack), .NET_DEV_IDX(didx), .NET_DEV_IP(dip), .DEV_EXCH(exch),
      .CYCLE_TICK(tick), .TX_STB(tx_stb), .TX_DATA_VALID(tx_v), .TX_DATA(tx_d), .RX_STB(rx_stb),
      .RX_DATA(rx_d), .BUS_FAULT_INDICATOR(bf), .BUS_STATE_INDICATOR(sti), .COMM_READY(rdy));

   iocss_remote REM (.clk(clk), .rst_n(rstn), .slow(slow), .disc_set(dset), .rel_req(rreq),
      .dev_idx(didx), .dev_ip(dip), .disc_ack(dack), .rel_ack(rack));

   always #10 clk = ~clk;

   task automatic step(int n = 1);
      repeat (n) @(posedge clk);
      #2;
   endtask

   task automatic chk(logic [31:0] got, logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Counts indicator changes over 64 cycles
   task automatic flips(bit sel, output int n);
      logic p;
      p = sel ? sti : bf;
      n = 0;
      repeat (64) begin
         step();
         if ((sel ? sti : bf) !== p) n++;
         p = sel ? sti : bf;
      end
   endtask

   task automatic t_idle();
      chk({bf, sti}, 0);
      chk({io_en, reach}, 0);
      srch = 1'b1;
      tick = 1'b1;
      rx_stb = 1'b1;
      step();
      srch = 1'b0;
      tick = 1'b0;
      rx_stb = 1'b0;
      chk(srsp, 1);
      chk(tx_stb, 0);
      chk(in_stb, 0);
      bus_ok = 1'b1;
      step(2);
      chk(reach, 1);
      chk({bf, sti, io_en}, 0);
      $display("t_idle done");
   endtask

   task automatic t_cfg(logic [3:0] cnt, iocss_word_t ip);
      int k, r0;
      r0 = REM.n_rel;
      cfg_b = 1'b1;
      step();
      cfg_b = 1'b0;
      cfg_wr = 1'b1;
      for (int i = 0; i < cnt; i++) begin
         cfg_idx = i[2:0];
         cfg_ip = ip + i;
         cfg_lk = (i == 0);
         step();
      end
      cfg_wr = 1'b0;
      cfg_e = 1'b1;
      cfg_cnt = cnt;
      step();
      cfg_e = 1'b0;
      k = 0;
      while (rdy !== 1'b1 && k < 400) begin
         step();
         k++;
      end
      step(2);
      chk(rdy, 1);
      chk(io_en, 1);
      for (int i = 0; i < cnt; i++) chk(REM.ip_seen[i], ip + i);
      chk(REM.n_rel - r0, cnt);
      chk({bf, sti}, 2'b01);
      flips(1, k);
      chk(k, 0);
      $display("t_cfg done");
   endtask

   task automatic t_ind();
      int n;
      exch = 8'h01;
      step(2);
      chk(rdy, 0);
      flips(0, n);
      chk(n, 16);
      link = 1'b0;
      step(2);
      flips(0, n);
      chk(n, 0);
      chk(bf, 1);
      link = 1'b1;
      exch = 8'hff;
      if_ok = 1'b0;
      step(2);
      flips(1, n);
      chk(n, 8);
      ip_ok = 1'b0;
      step(2);
      flips(1, n);
      chk(n, 4);
      if_ok = 1'b1;
      ip_ok = 1'b1;
      step(2);
      $display("t_ind done");
   endtask

   task automatic t_cyc();
      for (int m = 0; m < 2; m++) begin
         run = m[0];
         out_d = 32'ha5c3_0f10 + m;
         rx_d = 32'h1234_5670 + m;
         step();
         tick = 1'b1;
         rx_stb = 1'b1;
         step();
         tick = 1'b0;
         rx_stb = 1'b0;
         chk({tx_stb, tx_v, out_rd}, {1'b1, m[0], m[0]});
         chk(tx_d, m ? out_d : 32'h0);
         chk(in_stb, 1);
         chk(in_d, rx_d);
         step();
         chk({tx_stb, in_stb}, 0);
      end
      $display("t_cyc done");
   endtask

   task automatic finish_test();
      $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   initial begin
      #100us;
      error_cnt++;
      finish_test();
   end

   initial begin
      step(20);
      rstn = 1'b1;
      t_idle();
      exch = 8'hff;
      t_cfg(2, 32'h0a00_0010);
      t_ind();
      t_cyc();
      slow = 1'b1;
      t_cfg(1, 32'h0a00_0040);
      finish_test();
   end
endmodule
